// File: verilog/dbgbc_pkg.sv
package dbgbc_pkg;

    // serial command codes
    localparam logic [7:0] CMD_SHADOW_PC_WRITE = 8'h4F;
    localparam logic [7:0] CMD_BKPT_READ = 8'hE2;
    localparam logic [7:0] CMD_BKPT_WRITE = 8'hC2;
    localparam logic [7:0] CMD_STATUS_READ = 8'hE4;
    localparam logic [7:0] CMD_CONTROL_WRITE = 8'hC4;
    localparam logic [7:0] CMD_BACKGROUND = 8'h90;
    localparam logic [7:0] CMD_GO = 8'h08;
    localparam logic [7:0] CMD_SINGLE_STEP = 8'h10;
    localparam logic [7:0] CMD_STATUS_BYTE_READ = 8'hE1;
    localparam logic [7:0] CMD_STATUS_BYTE_WRITE = 8'hC1;

    // debug_status_control field positions
    localparam int SCR_BGEN = 7;
    localparam int SCR_ACTIVE = 6;
    localparam int SCR_BREAKPOINT_ENABLE = 5;
    localparam int SCR_FTS = 4;
    localparam int SCR_WS = 2;
    localparam int SCR_WSF = 1;

    // reset values
    localparam logic [7:0] SCR_RESET = 8'h00;
    localparam logic [15:0] BKPT_RESET = 16'h0000;
    localparam logic [13:0] SPC_RESET = 14'h0000;

    // timing in clock cycles
    localparam logic [4:0] MEM_DELAY_CYCLES = 5'h10;
    localparam logic [4:0] BIT_MIN_CYCLES = 5'h10;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_STEAL = 2'b01,
        ST_DELAY = 2'b10
    } dbgbc_state_e;

endpackage

// File: verilog/dbgbc_breakpoint.sv
`timescale 1ns/100ps
module dbgbc_breakpoint
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // settings
    input wire logic enable,
    input wire logic forceSel,
    input wire logic [15:0] matchAddr,
    // cpu side
    input wire logic [13:0] cpuAddr,
    input wire logic cpuAccess,
    input wire logic cpuOpFetch,
    input wire logic cpuTagAtTop,
    input wire logic cpuInstrBoundary,
    // results
    output logic tagMark,
    output logic hit
);
    logic pending_r;
    logic pending_nxt;
    logic tag_r;
    logic tag_nxt;
    logic addrHit;

    always_comb
    begin
        addrHit = (cpuAddr == matchAddr[13:0]); // RULE_02 RULE_23
        pending_nxt = pending_r;
        if (!enable || !forceSel || cpuInstrBoundary)
        begin
            pending_nxt = 1'b0;
        end
        if (enable && forceSel && cpuAccess && addrHit)
        begin
            pending_nxt = 1'b1; // RULE_03
        end
        tag_nxt = enable && !forceSel && cpuOpFetch && addrHit; // RULE_04 RULE_07
        hit = enable && (forceSel ? (pending_r && cpuInstrBoundary) // RULE_03 RULE_06
            : cpuTagAtTop); // RULE_04
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pending_r <= 1'b0;
            tag_r <= 1'b0;
        end
        else
        begin
            pending_r <= pending_nxt;
            tag_r <= tag_nxt;
        end
    end

    assign tagMark = tag_r;

endmodule // dbgbc_breakpoint

// File: verilog/dbgbc_bit_guard.sv
`timescale 1ns/100ps
module dbgbc_bit_guard
    import dbgbc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // link bit edges
    input wire logic bitEdge,
    // result
    output logic tooShort
);
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic armed_r;
    logic armed_nxt;
    logic short_r;
    logic short_nxt;

    always_comb
    begin
        cnt_nxt = cnt_r;
        armed_nxt = armed_r;
        short_nxt = 1'b0;
        if (bitEdge)
        begin
            short_nxt = armed_r && (cnt_r < BIT_MIN_CYCLES); // RULE_17
            cnt_nxt = 5'h01;
            armed_nxt = 1'b1;
        end
        else if (cnt_r < BIT_MIN_CYCLES)
        begin
            cnt_nxt = cnt_r + 5'h01;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_r <= 5'h00;
            armed_r <= 1'b0;
            short_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            armed_r <= armed_nxt;
            short_r <= short_nxt;
        end
    end

    assign tooShort = short_r;

endmodule // dbgbc_bit_guard

// File: verilog/dbgbc_cmd_exec.sv
// How it works
// [RULE_01] shadow pc write keeps low 14 bits
// [RULE_02] one breakpoint compares cpu address, 14 bits
// [RULE_03] forced: any access halts at next boundary
// [RULE_04] tagged: tagged opcode halts at queue end
// [RULE_05] host puts tagged breakpoints only on opcodes
// [RULE_06] enable resets low; low blocks all breakpoints
// [RULE_07] select bit: 1 forced, 0 tagged
// [RULE_08] debug registers reachable only by serial commands
// [RULE_09] status/control and breakpoint commands access registers
// [RULE_10] background disabled: entry becomes illegal opcode reset
// [RULE_11] background enable keeps debug clock running
// [RULE_12] background command wakes low-power target
// [RULE_13] go into wait or stop enters it
// [RULE_14] single step completes wait/stop, then halts
// [RULE_15] memory commands steal cycles, no halt
// [RULE_16] memory command waits 16 bus cycles
// [RULE_17] each bit lasts at least 16 clocks
// [RULE_18] register commands answer without delay
// [RULE_19] access meeting low-power entry sets failure bit
// [RULE_20] status byte read returns status, then data
// [RULE_21] status byte write returns one status byte
// [RULE_22] breakpoint read E2, write C2, 16 bits
// [RULE_23] comparator ignores upper two breakpoint bits
`timescale 1ns/100ps
module dbgbc_cmd_exec
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // decoded commands from the link layer
    input wire logic cmdValid,
    input wire logic [7:0] cmdCode,
    input wire logic [15:0] cmdAddr,
    input wire logic [15:0] cmdData,
    input wire logic bitEdge,
    // answers to the link layer
    output logic cmdReady,
    output logic rspValid,
    output logic [15:0] rspData,
    output logic bitTooShort,
    // cpu status
    input wire logic [13:0] cpuAddr,
    input wire logic cpuAccess,
    input wire logic cpuOpFetch,
    input wire logic cpuTagAtTop,
    input wire logic cpuInstrBoundary,
    input wire logic cpuInLowPower,
    input wire logic cpuEnteringLowPower,
    input wire logic [7:0] memRdata,
    // cpu control
    output logic tagMark,
    output logic cpuHalt,
    output logic bgEnter,
    output logic illegalOpReset,
    output logic lowPowerWake,
    output logic dbgClkKeep,
    output logic shadowPcWrite,
    output logic [13:0] shadowPc,
    // stolen memory cycle
    output logic memStrobe,
    output logic memWrite,
    output logic [15:0] memAddr,
    output logic [7:0] memWdata
);
    import dbgbc_pkg::*;

    dbgbc_state_e state_r;
    dbgbc_state_e state_nxt;
    logic [4:0] delayCnt_r;
    logic [4:0] delayCnt_nxt;
    logic bgEnable_r;
    logic bgEnable_nxt;
    logic breakpoint_enable_r;
    logic breakpoint_enable_nxt;
    logic fts_r;
    logic fts_nxt;
    logic wsf_r;
    logic wsf_nxt;
    logic ws_r;
    logic ws_nxt;
    logic bgActive_r;
    logic bgActive_nxt;
    logic stepping_r;
    logic stepping_nxt;
    logic [15:0] bkpt_r;
    logic [15:0] bkpt_nxt;
    logic [13:0] spc_r;
    logic [13:0] spc_nxt;
    logic spcWr_r;
    logic spcWr_nxt;
    logic ready_r;
    logic ready_nxt;
    logic rspValid_r;
    logic rspValid_nxt;
    logic [15:0] rspData_r;
    logic [15:0] rspData_nxt;
    logic bgEnter_r;
    logic bgEnter_nxt;
    logic illegal_r;
    logic illegal_nxt;
    logic wake_r;
    logic wake_nxt;
    logic clkKeep_r;
    logic clkKeep_nxt;
    logic memStrobe_r;
    logic memStrobe_nxt;
    logic memWrite_r;
    logic memWrite_nxt;
    logic [15:0] memAddr_r;
    logic [15:0] memAddr_nxt;
    logic [7:0] memWdata_r;
    logic [7:0] memWdata_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic bpHit;
    logic bgEvent;
    logic accept;
    logic [7:0] scr;

    dbgbc_breakpoint u_breakpoint
    (
        .clk(clk),
        .nrst(nrst),
        .enable(breakpoint_enable_r),
        .forceSel(fts_r),
        .matchAddr(bkpt_r),
        .cpuAddr(cpuAddr),
        .cpuAccess(cpuAccess),
        .cpuOpFetch(cpuOpFetch),
        .cpuTagAtTop(cpuTagAtTop),
        .cpuInstrBoundary(cpuInstrBoundary),
        .tagMark(tagMark),
        .hit(bpHit)
    );

    dbgbc_bit_guard u_bit_guard
    (
        .clk(clk),
        .nrst(nrst),
        .bitEdge(bitEdge),
        .tooShort(bitTooShort)
    );

    always_comb
    begin
        scr = SCR_RESET;
        scr[SCR_BGEN] = bgEnable_r;
        scr[SCR_ACTIVE] = bgActive_r;
        scr[SCR_BREAKPOINT_ENABLE] = breakpoint_enable_r;
        scr[SCR_FTS] = fts_r;
        scr[SCR_WS] = ws_r;
        scr[SCR_WSF] = wsf_r;

        accept = cmdValid && ready_r;
        state_nxt = state_r;
        delayCnt_nxt = delayCnt_r;
        bgEnable_nxt = bgEnable_r;
        breakpoint_enable_nxt = breakpoint_enable_r;
        fts_nxt = fts_r;
        wsf_nxt = wsf_r;
        ws_nxt = cpuInLowPower;
        bgActive_nxt = bgActive_r;
        stepping_nxt = stepping_r;
        bkpt_nxt = bkpt_r;
        spc_nxt = spc_r;
        spcWr_nxt = 1'b0;
        ready_nxt = ready_r;
        rspValid_nxt = 1'b0;
        rspData_nxt = rspData_r;
        bgEnter_nxt = 1'b0;
        illegal_nxt = 1'b0;
        wake_nxt = 1'b0;
        memStrobe_nxt = 1'b0;
        memWrite_nxt = memWrite_r;
        memAddr_nxt = memAddr_r;
        memWdata_nxt = memWdata_r;
        rdata_nxt = rdata_r;
        bgEvent = 1'b0;

        // commands, reachable only through the serial link
        if (accept) // RULE_08
        begin
            unique case (cmdCode)
                CMD_STATUS_READ:
                begin
                    rspData_nxt = {8'h00, scr}; // RULE_09 RULE_18
                    rspValid_nxt = 1'b1;
                    wsf_nxt = 1'b0;
                end
                CMD_CONTROL_WRITE:
                begin
                    bgEnable_nxt = cmdData[SCR_BGEN]; // RULE_09
                    breakpoint_enable_nxt = cmdData[SCR_BREAKPOINT_ENABLE]; // RULE_06
                    fts_nxt = cmdData[SCR_FTS]; // RULE_07
                end
                CMD_BKPT_READ:
                begin
                    rspData_nxt = bkpt_r; // RULE_22 RULE_18
                    rspValid_nxt = 1'b1;
                end
                CMD_BKPT_WRITE:
                begin
                    bkpt_nxt = cmdData; // RULE_22 RULE_09
                end
                CMD_SHADOW_PC_WRITE:
                begin
                    spc_nxt = cmdData[13:0]; // RULE_01
                    spcWr_nxt = 1'b1;
                end
                CMD_BACKGROUND:
                begin
                    bgEvent = !bgActive_r; // RULE_12
                end
                CMD_GO:
                begin
                    if (bgActive_r)
                    begin
                        bgActive_nxt = 1'b0; // RULE_13
                    end
                end
                CMD_SINGLE_STEP:
                begin
                    if (bgActive_r)
                    begin
                        bgActive_nxt = 1'b0;
                        stepping_nxt = 1'b1; // RULE_14
                    end
                end
                CMD_STATUS_BYTE_READ,
                CMD_STATUS_BYTE_WRITE:
                begin
                    memAddr_nxt = cmdAddr; // RULE_16
                    memWdata_nxt = cmdData[7:0];
                    memWrite_nxt = (cmdCode == CMD_STATUS_BYTE_WRITE);
                    memStrobe_nxt = 1'b1; // RULE_15
                    ready_nxt = 1'b0;
                    delayCnt_nxt = 5'h01;
                    state_nxt = ST_STEAL;
                end
                default:
                begin
                    ready_nxt = ready_r;
                end
            endcase
        end

        // stolen cycle and fixed delay
        unique case (state_r)
            ST_IDLE:
            begin
                state_nxt = state_nxt;
            end
            ST_STEAL:
            begin
                rdata_nxt = memRdata;
                if (cpuEnteringLowPower)
                begin
                    wsf_nxt = 1'b1; // RULE_19
                end
                delayCnt_nxt = delayCnt_r + 5'h01;
                state_nxt = ST_DELAY;
            end
            ST_DELAY:
            begin
                delayCnt_nxt = delayCnt_r + 5'h01;
                // answer lands on the 15th edge after the accept edge
                if (delayCnt_r == (MEM_DELAY_CYCLES - 5'h01)) // RULE_16
                begin
                    delayCnt_nxt = 5'h00;
                    state_nxt = ST_IDLE;
                    ready_nxt = 1'b1;
                    rspValid_nxt = 1'b1;
                    if (memWrite_r)
                    begin
                        rspData_nxt = {8'h00, scr}; // RULE_21
                    end
                    else
                    begin
                        rspData_nxt = {scr, rdata_r}; // RULE_20
                    end
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
                ready_nxt = 1'b1;
            end
        endcase

        // single step ends after one instruction, or in low power
        if (stepping_r && (cpuInstrBoundary || cpuInLowPower))
        begin
            stepping_nxt = 1'b0;
            bgEvent = 1'b1; // RULE_14
        end
        if (bpHit && !bgActive_r)
        begin
            bgEvent = 1'b1; // RULE_03 RULE_04
        end

        // entry into active background
        if (bgEvent)
        begin
            if (bgEnable_r)
            begin
                bgActive_nxt = 1'b1;
                bgEnter_nxt = 1'b1;
                wake_nxt = cpuInLowPower; // RULE_12
            end
            else
            begin
                illegal_nxt = 1'b1; // RULE_10
                stepping_nxt = 1'b0;
            end
        end

        clkKeep_nxt = bgEnable_nxt; // RULE_11
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r <= ST_IDLE;
            delayCnt_r <= 5'h00;
            bgEnable_r <= 1'b0;
            breakpoint_enable_r <= 1'b0;
            fts_r <= 1'b0;
            wsf_r <= 1'b0;
            ws_r <= 1'b0;
            bgActive_r <= 1'b0;
            stepping_r <= 1'b0;
            bkpt_r <= BKPT_RESET;
            spc_r <= SPC_RESET;
            spcWr_r <= 1'b0;
            ready_r <= 1'b1;
            rspValid_r <= 1'b0;
            rspData_r <= 16'h0000;
            bgEnter_r <= 1'b0;
            illegal_r <= 1'b0;
            wake_r <= 1'b0;
            clkKeep_r <= 1'b0;
            memStrobe_r <= 1'b0;
            memWrite_r <= 1'b0;
            memAddr_r <= 16'h0000;
            memWdata_r <= 8'h00;
            rdata_r <= 8'h00;
        end
        else
        begin
            state_r <= state_nxt;
            delayCnt_r <= delayCnt_nxt;
            bgEnable_r <= bgEnable_nxt;
            breakpoint_enable_r <= breakpoint_enable_nxt;
            fts_r <= fts_nxt;
            wsf_r <= wsf_nxt;
            ws_r <= ws_nxt;
            bgActive_r <= bgActive_nxt;
            stepping_r <= stepping_nxt;
            bkpt_r <= bkpt_nxt;
            spc_r <= spc_nxt;
            spcWr_r <= spcWr_nxt;
            ready_r <= ready_nxt;
            rspValid_r <= rspValid_nxt;
            rspData_r <= rspData_nxt;
            bgEnter_r <= bgEnter_nxt;
            illegal_r <= illegal_nxt;
            wake_r <= wake_nxt;
            clkKeep_r <= clkKeep_nxt;
            memStrobe_r <= memStrobe_nxt;
            memWrite_r <= memWrite_nxt;
            memAddr_r <= memAddr_nxt;
            memWdata_r <= memWdata_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign cmdReady = ready_r;
    assign rspValid = rspValid_r;
    assign rspData = rspData_r;
    assign cpuHalt = bgActive_r;
    assign bgEnter = bgEnter_r;
    assign illegalOpReset = illegal_r;
    assign lowPowerWake = wake_r;
    assign dbgClkKeep = clkKeep_r;
    assign shadowPcWrite = spcWr_r;
    assign shadowPc = spc_r;
    assign memStrobe = memStrobe_r;
    assign memWrite = memWrite_r;
    assign memAddr = memAddr_r;
    assign memWdata = memWdata_r;

endmodule // dbgbc_cmd_exec

// File: bench/dbgbc_checker.sv
`timescale 1ns/100ps
module dbgbc_checker
    import dbgbc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // command side
    input wire logic cmdValid,
    input wire logic [7:0] cmdCode,
    input wire logic [15:0] cmdAddr,
    input wire logic [15:0] cmdData,
    input wire logic bitEdge,
    input wire logic cmdReady,
    input wire logic rspValid,
    input wire logic bitTooShort,
    // cpu side
    input wire logic cpuTagAtTop,
    input wire logic cpuInstrBoundary,
    input wire logic cpuHalt,
    input wire logic bgEnter,
    input wire logic illegalOpReset,
    input wire logic dbgClkKeep,
    input wire logic shadowPcWrite,
    input wire logic [13:0] shadowPc,
    input wire logic memStrobe,
    input wire logic [15:0] memAddr
);
    logic take, tag, memCmd, short;
    logic [7:0] scr_r, scr_nxt;
    logic [4:0] gap_r, gap_nxt;
    logic seen_r, seen_nxt;
    // copy of control bits and bit spacing
    always_comb
    begin
        take = cmdValid && cmdReady;
        memCmd = cmdCode == CMD_STATUS_BYTE_READ || cmdCode == CMD_STATUS_BYTE_WRITE;
        scr_nxt = (take && cmdCode == CMD_CONTROL_WRITE) ? cmdData[7:0] : scr_r;
        gap_nxt = bitEdge ? 5'h01 : ((gap_r == 5'h1F) ? gap_r : gap_r + 5'h01);
        seen_nxt = seen_r || bitEdge;
        short = seen_r && gap_r < 5'h10;
        tag = cpuTagAtTop && !cpuHalt && !take && !cpuInstrBoundary;
    end
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            scr_r <= 8'h00;
            gap_r <= 5'h00;
            seen_r <= 1'b0;
        end
        else
        begin
            scr_r <= scr_nxt;
            gap_r <= gap_nxt;
            seen_r <= seen_nxt;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    spc_keep_a: assert property (take && cmdCode == CMD_SHADOW_PC_WRITE
        |=> shadowPcWrite && shadowPc == $past(cmdData[13:0])) else $error("shadow pc");
    reg_answer_a: assert property (take && (cmdCode == CMD_BKPT_READ
        || cmdCode == CMD_STATUS_READ) |=> rspValid && cmdReady) else $error("reg answer");
    mem_steal_a: assert property (take && memCmd
        |=> memStrobe && !cmdReady && memAddr == $past(cmdAddr)) else $error("mem steal");
    mem_delay_a: assert property (take && memCmd
        |-> ##16 (rspValid && cmdReady)) else $error("mem delay");
    tag_halt_a: assert property (tag && scr_r[SCR_BREAKPOINT_ENABLE] && !scr_r[SCR_FTS]
        && scr_r[SCR_BGEN] |=> bgEnter && cpuHalt) else $error("tag halt");
    tag_off_a: assert property (tag && !scr_r[SCR_BREAKPOINT_ENABLE]
        |=> !bgEnter && !illegalOpReset) else $error("bkpt off");
    tag_select_a: assert property (tag && scr_r[SCR_FTS] |=> !bgEnter)
        else $error("tag select");
    illegal_op_a: assert property (tag && scr_r[SCR_BREAKPOINT_ENABLE] && !scr_r[SCR_FTS]
        && !scr_r[SCR_BGEN] |=> illegalOpReset && !bgEnter) else $error("illegal op");
    clk_keep_a: assert property (take && cmdCode == CMD_CONTROL_WRITE
        |=> dbgClkKeep == $past(cmdData[7])) else $error("clock keep");
    bit_short_a: assert property (bitEdge |=> bitTooShort == $past(short))
        else $error("bit short");
    cover property (tag && scr_r[SCR_BREAKPOINT_ENABLE] && scr_r[SCR_BGEN] ##1 bgEnter);
    cover property (take && memCmd ##16 rspValid);
    cover property (bitEdge && short);
endmodule // dbgbc_checker

bind dbgbc_cmd_exec dbgbc_checker dbgbc_checker_i
(
    .clk, .nrst, .cmdValid, .cmdCode, .cmdAddr, .cmdData, .bitEdge, .cmdReady,
    .rspValid, .bitTooShort, .cpuTagAtTop, .cpuInstrBoundary, .cpuHalt, .bgEnter,
    .illegalOpReset, .dbgClkKeep, .shadowPcWrite, .shadowPc, .memStrobe, .memAddr
);

// File: bench/dbgbc_pod_model.sv
`timescale 1ns/100ps
module dbgbc_pod_model
(
    // clock
    input wire logic clk,
    // command lines
    output logic cmdValid,
    output logic [7:0] cmdCode,
    output logic [15:0] cmdAddr,
    output logic [15:0] cmdData,
    output logic bitEdge
);
    initial
    begin
        cmdValid = 1'b0;
        cmdCode = 8'h00;
        cmdAddr = 16'h0000;
        cmdData = 16'h0000;
        bitEdge = 1'b0;
    end
    // one command, held over one accepting edge
    task automatic send(input logic [7:0] code, input logic [15:0] addr, input logic [15:0] data);
        @(posedge clk);
        #1;
        cmdValid = 1'b1;
        cmdCode = code;
        cmdAddr = addr;
        cmdData = data;
        @(posedge clk);
        #1;
        cmdValid = 1'b0;
        cmdCode = ~code;
        cmdAddr = ~addr;
        cmdData = ~data;
    endtask
    // one bit edge, next edge k cycles later
    task automatic bitTime(input int k);
        @(posedge clk);
        #1;
        bitEdge = 1'b1;
        @(posedge clk);
        #1;
        bitEdge = 1'b0;
        repeat (k - 2) @(posedge clk);
    endtask
endmodule // dbgbc_pod_model

// File: bench/tb_dbgbc_cmd_exec.sv
`timescale 1ns/100ps
module tb_dbgbc_cmd_exec;
    import dbgbc_pkg::*;
    logic clk, nrst, cmdValid, bitEdge, cmdReady, rspValid, bitTooShort;
    logic [7:0] cmdCode, memRdata, memWdata;
    logic [15:0] cmdAddr, cmdData, rspData, memAddr;
    logic [13:0] cpuAddr, shadowPc;
    logic cpuAccess, cpuOpFetch, cpuTagAtTop, cpuInstrBoundary, cpuInLowPower;
    logic cpuEnteringLowPower, tagMark, cpuHalt, bgEnter, illegalOpReset;
    logic lowPowerWake, dbgClkKeep, shadowPcWrite, memStrobe, memWrite;
    int badCount, checkCount, shortCount;
    dbgbc_cmd_exec dbgbc_cmd_exec_i
    (
        .clk, .nrst, .cmdValid, .cmdCode, .cmdAddr, .cmdData, .bitEdge, .cmdReady,
        .rspValid, .rspData, .bitTooShort, .cpuAddr, .cpuAccess, .cpuOpFetch,
        .cpuTagAtTop, .cpuInstrBoundary, .cpuInLowPower, .cpuEnteringLowPower,
        .memRdata, .tagMark, .cpuHalt, .bgEnter, .illegalOpReset, .lowPowerWake,
        .dbgClkKeep, .shadowPcWrite, .shadowPc, .memStrobe, .memWrite, .memAddr,
        .memWdata
    );
    dbgbc_pod_model dbgbc_pod_model_i
    (
        .clk, .cmdValid, .cmdCode, .cmdAddr, .cmdData, .bitEdge
    );
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(negedge clk) if (bitTooShort === 1'b1) shortCount++;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            badCount++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cmd(input logic [7:0] code, input logic [15:0] data);
        dbgbc_pod_model_i.send(code, 16'h0000, data);
    endtask
    task automatic tagPulse;
        cpuTagAtTop = 1'b1;
        tick(1);
        cpuTagAtTop = 1'b0;
    endtask
    task automatic finishTest;
        $display("checks %0d mismatches %0d", checkCount, badCount);
        if (badCount == 0 && checkCount > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic tRegs;
        chk(cmdReady, 1);
        cmd(CMD_STATUS_READ, 0);
        chk(rspData, 16'h0000);
        cmd(CMD_BKPT_WRITE, 16'hC123);
        cmd(CMD_BKPT_READ, 0);
        chk(rspData, 16'hC123);
        cmd(CMD_SHADOW_PC_WRITE, 16'hFFFF);
        chk(shadowPc, 16'h3FFF);
    endtask
    task automatic tMemory;
        memRdata = 8'h5A;
        dbgbc_pod_model_i.send(CMD_STATUS_BYTE_READ, 16'h1234, 16'h0000);
        chk({memStrobe, memWrite, cpuHalt, memAddr}, 19'h41234);
        tick(15);
        chk({rspValid, rspData}, 17'h1005A);
        cpuEnteringLowPower = 1'b1;
        dbgbc_pod_model_i.send(CMD_STATUS_BYTE_WRITE, 16'h0042, 16'h00A5);
        chk({memWrite, memWdata}, 9'h1A5);
        tick(1);
        cpuEnteringLowPower = 1'b0;
        tick(14);
        chk({rspValid, rspData}, 17'h10002);
        cmd(CMD_STATUS_READ, 0);
        cmd(CMD_STATUS_READ, 0);
        chk(rspData, 16'h0000);
    endtask
    task automatic tBreak;
        cmd(CMD_CONTROL_WRITE, 16'h00A0);
        cpuAddr = 14'h0123;
        cpuAccess = 1'b1;
        cpuOpFetch = 1'b1;
        tick(1);
        cpuAccess = 1'b0;
        cpuOpFetch = 1'b0;
        chk(tagMark, 1);
        tagPulse();
        chk({bgEnter, cpuHalt, dbgClkKeep}, 3'h7);
        cmd(CMD_STATUS_READ, 0);
        chk(rspData, 16'h00E0);
        cmd(CMD_GO, 0);
        chk(cpuHalt, 0);
        cmd(CMD_CONTROL_WRITE, 16'h0080);
        tagPulse();
        chk({bgEnter, cpuHalt}, 2'h0);
        cmd(CMD_CONTROL_WRITE, 16'h00B0);
        tagPulse();
        chk(bgEnter, 0);
        cpuAccess = 1'b1;
        tick(1);
        cpuAccess = 1'b0;
        tick(1);
        chk(bgEnter, 0);
        cpuInstrBoundary = 1'b1;
        tick(1);
        cpuInstrBoundary = 1'b0;
        chk({bgEnter, cpuHalt}, 2'h3);
        cmd(CMD_GO, 0);
        cmd(CMD_CONTROL_WRITE, 16'h0020);
        tagPulse();
        chk({illegalOpReset, bgEnter, cpuHalt, dbgClkKeep}, 4'h8);
    endtask
    task automatic tLowPower;
        cmd(CMD_CONTROL_WRITE, 16'h0080);
        cpuInLowPower = 1'b1;
        tick(2);
        cmd(CMD_STATUS_READ, 0);
        chk(rspData, 16'h0084);
        cmd(CMD_BACKGROUND, 0);
        chk({bgEnter, lowPowerWake}, 2'h3);
        cmd(CMD_SINGLE_STEP, 0);
        chk(cpuHalt, 0);
        tick(1);
        chk({bgEnter, lowPowerWake}, 2'h3);
        cpuInLowPower = 1'b0;
    endtask
    task automatic tBits;
        dbgbc_pod_model_i.bitTime(16);
        dbgbc_pod_model_i.bitTime(16);
        dbgbc_pod_model_i.bitTime(15);
        dbgbc_pod_model_i.bitTime(16);
        tick(2);
        chk(shortCount, 1);
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        badCount++;
        finishTest();
    end
    initial
    begin
        nrst = 1'b0;
        {cpuAddr, cpuAccess, cpuOpFetch, cpuTagAtTop, cpuInstrBoundary} = '0;
        {cpuInLowPower, cpuEnteringLowPower, memRdata} = '0;
        tick(10);
        nrst = 1'b1;
        tRegs();
        tMemory();
        tBreak();
        tLowPower();
        tBits();
        finishTest();
    end
endmodule // tb_dbgbc_cmd_exec
